// ===== ibeoi_pkg.sv
// Shared constants, types and checksum helpers for the END_OF_INTERRUPT_MESSAGE message link
package ibeoi_pkg;

    // Frame cycle counter; cycle numbers run from 1 to 14
    typedef logic [3:0] ibeoi_cnt_t;

    // Position of each field within the end-of-interrupt frame
    localparam ibeoi_cnt_t CYC_NONE = 4'h0;
    localparam ibeoi_cnt_t CYC_CODE = 4'h1;
    localparam ibeoi_cnt_t CYC_FIRST_SAMPLE = 4'h2;
    localparam ibeoi_cnt_t CYC_ARB_FIRST = 4'h2;
    localparam ibeoi_cnt_t CYC_ARB_LAST = 4'h5;
    localparam ibeoi_cnt_t CYC_VEC_FIRST = 4'h6;
    localparam ibeoi_cnt_t CYC_VEC_LAST = 4'h9;
    localparam ibeoi_cnt_t CYC_CSUM = 4'ha;
    localparam ibeoi_cnt_t CYC_GAP = 4'hb;
    localparam ibeoi_cnt_t CYC_STAT0 = 4'hc;
    localparam ibeoi_cnt_t CYC_STAT1 = 4'hd;
    localparam ibeoi_cnt_t CYC_IDLE = 4'he;

    // Two-bit values seen on the bus
    localparam logic [1:0] PAIR_ZERO = 2'h0;
    localparam logic [1:0] CODE_EOI = 2'h3;
    localparam logic [1:0] STAT_CS_OK = 2'h0;
    localparam logic [1:0] STAT_CS_ERR = 2'h3;
    localparam logic [1:0] STAT_ACCEPT = 2'h2;
    localparam logic [1:0] STAT_RETRY = 2'h3;

    // Value after reset of a one-flop toggle and of a three-flop synchroniser chain
    localparam logic TGL_RESET = 1'b0;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // One checksum addition; fold adds the carry back into the sum
    function automatic logic [1:0] csum_step(input logic [1:0] acc,
                                             input logic [1:0] val,
                                             input logic fold);
        logic [2:0] s;
        s = {1'b0, acc} + {1'b0, val};
        if (fold) begin
            csum_step = s[1:0] + {1'b0, s[2]};
        end else begin
            csum_step = s[1:0];
        end
    endfunction

    // Checksum of a whole vector, four pairs, high pair first
    function automatic logic [1:0] csum_vec(input logic [7:0] vec);
        logic [1:0] acc;
        acc = vec[7:6];
        acc = csum_step(acc, vec[5:4], 1'b1);
        acc = csum_step(acc, vec[3:2], 1'b1);
        acc = csum_step(acc, vec[1:0], 1'b0);
        csum_vec = acc;
    endfunction

endpackage

// ===== ibeoi_bus_if.sv
// Two-bit wired-OR interrupt bus shared by the two controller ends
`timescale 1ns/1ps
interface ibeoi_bus_if;
    logic [1:0] lic_out; // Local controller drive value
    logic lic_oe; // Local controller drives both bits
    logic [1:0] ioc_out; // I/O controller drive value
    logic ioc_oe; // I/O controller drives both bits
    logic [1:0] ext_out; // Extra agent, driven by the bench only
    logic ext_oe; // Extra agent enable, driven by the bench only
    logic [1:0] level; // Resolved bus level

    // Undriven bits read low; any driver at one pulls the bit high
    assign level = (lic_oe ? lic_out : 2'h0) | (ioc_oe ? ioc_out : 2'h0)
                 | (ext_oe ? ext_out : 2'h0);

    modport lic (output lic_out, output lic_oe, input level);
    modport ioc (output ioc_out, output ioc_oe, input level);
endinterface

// ===== ibeoi_ioc_end.sv
// I/O interrupt controller end: end-of-interrupt message receiver
`timescale 1ns/1ps
module ibeoi_ioc_end
    import ibeoi_pkg::*;
(
    ibeoi_bus_if.ioc bus,
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic retry_req,
    output logic eoi_valid,
    output logic [7:0] eoi_vector,
    output logic [3:0] eoi_arb_id,
    output logic cs_error
);

    typedef enum {IOC_IDLE, IOC_RECV} ibeoi_ioc_state_t;

    ibeoi_ioc_state_t state_reg; // Frame tracking state
    ibeoi_cnt_t cnt_reg; // Cycle number now on the bus
    logic [1:0] code_reg; // Message code of cycle 1
    logic [3:0] arb_sh_reg; // Arbitration identifier shifter
    logic [7:0] vec_sh_reg; // Vector shifter
    logic [1:0] acc_reg; // Running checksum
    logic err_reg; // Own checksum mismatch this frame
    logic ok_reg; // Frame accepted in status cycle 1
    logic [1:0] out_reg; // Drive value for next cycle
    logic oe_reg; // Drive enable for next cycle
    logic valid_reg;
    logic [7:0] vector_reg;
    logic [3:0] arb_reg;
    logic cs_err_reg;
    logic [1:0] bus_in; // Sampled on the link clock, same domain
    logic is_eoi; // Frame is an end-of-interrupt message

    assign bus_in = bus.level;
    assign is_eoi = (code_reg == CODE_EOI); // [RULE1]
    assign bus.ioc_out = out_reg;
    assign bus.ioc_oe = oe_reg;
    assign eoi_valid = valid_reg;
    assign eoi_vector = vector_reg;
    assign eoi_arb_id = arb_reg;
    assign cs_error = cs_err_reg;

    // Frame start and cycle count; any nonzero pair on an idle bus starts
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= IOC_IDLE;
            cnt_reg <= CYC_NONE;
            code_reg <= PAIR_ZERO;
        end else begin
            unique case (state_reg)
                IOC_IDLE: begin
                    if (bus_in != PAIR_ZERO) begin // [RULE14]
                        state_reg <= IOC_RECV;
                        cnt_reg <= CYC_FIRST_SAMPLE;
                        code_reg <= bus_in;
                    end
                end
                IOC_RECV: begin
                    // Other message kinds are only tracked, never decoded
                    if (cnt_reg == CYC_IDLE) begin
                        state_reg <= IOC_IDLE;
                        cnt_reg <= CYC_NONE;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1; // [RULE14]
                    end
                end
            endcase
        end
    end

    // Field capture and running checksum
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            arb_sh_reg <= 4'h0;
            vec_sh_reg <= 8'h00;
            acc_reg <= PAIR_ZERO;
        end else if (state_reg == IOC_IDLE) begin
            acc_reg <= PAIR_ZERO;
        end else if (cnt_reg >= CYC_ARB_FIRST && cnt_reg <= CYC_ARB_LAST) begin
            arb_sh_reg <= {arb_sh_reg[2:0], bus_in[1]};
        end else if (cnt_reg >= CYC_VEC_FIRST && cnt_reg <= CYC_VEC_LAST) begin
            vec_sh_reg <= {vec_sh_reg[5:0], bus_in};
            // Carry folds back on every addition but the last
            acc_reg <= csum_step(acc_reg, bus_in,
                                 cnt_reg != CYC_VEC_LAST); // [RULE8] [RULE9]
        end
    end

    // Checksum compare and accept decision
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            err_reg <= 1'b0;
            ok_reg <= 1'b0;
            cs_err_reg <= 1'b0;
        end else begin
            cs_err_reg <= 1'b0;
            if (state_reg == IOC_IDLE) begin
                err_reg <= 1'b0;
                ok_reg <= 1'b0;
            end else if (cnt_reg == CYC_CSUM && is_eoi) begin
                err_reg <= (bus_in != acc_reg); // [RULE10]
                cs_err_reg <= (bus_in != acc_reg);
            end else if (cnt_reg == CYC_STAT1) begin
                ok_reg <= is_eoi && (bus_in == STAT_ACCEPT); // [RULE13]
            end
        end
    end

    // Drive value for the next bus cycle
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= PAIR_ZERO;
            oe_reg <= 1'b0;
        end else if (state_reg == IOC_RECV && cnt_reg == CYC_GAP &&
                     err_reg) begin
            out_reg <= STAT_CS_ERR; // [RULE10]
            oe_reg <= 1'b1;
        end else if (state_reg == IOC_RECV && cnt_reg == CYC_STAT0 &&
                     is_eoi && !err_reg && bus_in == STAT_CS_OK) begin
            // Busy user side asks the sender to come again
            out_reg <= retry_req ? STAT_RETRY : STAT_ACCEPT; // [RULE13]
            oe_reg <= 1'b1;
        end else begin
            out_reg <= PAIR_ZERO;
            oe_reg <= 1'b0;
        end
    end

    // Deliver only accepted frames; errored ones are dropped
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            valid_reg <= 1'b0;
            vector_reg <= 8'h00;
            arb_reg <= 4'h0;
        end else begin
            valid_reg <= 1'b0;
            if (state_reg == IOC_RECV && cnt_reg == CYC_IDLE &&
                ok_reg) begin // [RULE11]
                valid_reg <= 1'b1;
                vector_reg <= vec_sh_reg;
                arb_reg <= arb_sh_reg;
            end
        end
    end

endmodule

// ===== ibeoi_lic_end.sv
// Local interrupt controller end: end-of-interrupt message sender
`timescale 1ns/1ps
// Behaviour
// (RULE1) Only END_OF_INTERRUPT_MESSAGE, short, non-focused kinds exist
// (RULE2) Send 14-cycle END_OF_INTERRUPT_MESSAGE after level interrupt
// (RULE3) END_OF_INTERRUPT_MESSAGE register write starts a message
// (RULE4) Cycle 1 is 11, cycles 11, 14 are 00
// (RULE5) Cycles 2-5: identifier MSB first, upper bit
// (RULE6) Cycles 6-9: vector pairs, high pair first
// (RULE7) Cycle 10 carries checksum of cycles 6-9
// (RULE8) Checksum is running sum of bit pairs
// (RULE9) Fold carry back except on last addition
// (RULE10) Mismatch drives 11 in cycle 12
// (RULE11) Errored messages are discarded by all
// (RULE12) Sender sees error and resends message
// (RULE13) Status: 00 ok, 11 error; 10 accept only; the receiver also answers 11 retry in cycle 13 on retry_req
// (RULE14) Sample each cycle, count from frame start
module ibeoi_lic_end
    import ibeoi_pkg::*;
(
    ibeoi_bus_if.lic bus,
    input wire logic clock,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic eoi_write,
    input wire logic [7:0] eoi_vector,
    input wire logic [3:0] arb_id,
    output logic busy,
    output logic eoi_done
);

    typedef enum {LIC_IDLE, LIC_SEND, LIC_LISTEN} ibeoi_lic_state_t;

    // Frame value that this end drives in cycle k
    function automatic logic [1:0] frame_val(input ibeoi_cnt_t k,
                                             input logic [3:0] arb,
                                             input logic [7:0] vec);
        logic [1:0] v;
        logic [1:0] p;
        v = PAIR_ZERO;
        p = 2'h0;
        if (k == CYC_CODE) begin
            v = CODE_EOI; // [RULE4]
        end else if (k >= CYC_ARB_FIRST && k <= CYC_ARB_LAST) begin
            p = 2'(CYC_ARB_LAST - k);
            v = {arb[p], 1'b0}; // [RULE5]
        end else if (k >= CYC_VEC_FIRST && k <= CYC_VEC_LAST) begin
            p = 2'(CYC_VEC_LAST - k);
            v = vec[{p, 1'b0} +: 2]; // [RULE6]
        end else if (k == CYC_CSUM) begin
            v = csum_vec(vec); // [RULE7] [RULE8] [RULE9]
        end
        frame_val = v;
    endfunction

    // System clock side
    logic [7:0] vec_hold_reg; // Stable while busy, read across domains
    logic [3:0] arb_hold_reg; // Stable while busy, read across domains
    logic req_tgl_reg; // Toggles once per accepted register write
    logic busy_reg;
    logic done_reg;
    logic [2:0] done_sync_reg; // Bit 0 feeds bit 1 only
    logic done_seen_reg;
    logic done_ev;

    // Link clock side
    logic [2:0] req_sync_reg; // Bit 0 feeds bit 1 only
    logic req_seen_reg;
    logic req_ev;
    logic pend_reg; // A message waits to be sent or resent
    logic [7:0] vec_reg;
    logic [3:0] arb_reg;
    logic done_tgl_reg;
    ibeoi_lic_state_t state_reg;
    ibeoi_cnt_t cnt_reg; // Cycle number now on the bus
    ibeoi_cnt_t cnt_nxt; // Cycle that the next drive value is for
    logic [1:0] code_reg; // Message code of the frame in progress
    logic lost_reg; // Lost arbitration this frame
    logic lose_now;
    logic [1:0] acc_reg; // Checksum of what the bus really showed
    logic err_reg; // Own checksum mismatch this frame
    logic retry_reg; // Frame needs sending again
    logic frame_ok;
    logic [1:0] out_reg;
    logic oe_reg;
    logic [1:0] bus_in; // Sampled on the link clock, same domain
    logic [1:0] cur_val; // What this end put on the bus now

    assign bus_in = bus.level;
    assign bus.lic_out = out_reg;
    assign bus.lic_oe = oe_reg;
    assign busy = busy_reg;
    assign eoi_done = done_reg;
    assign cnt_nxt = cnt_reg + 4'h1;
    assign cur_val = frame_val(cnt_reg, arb_reg, vec_reg);

    // A change counts once the second and third flops agree
    assign done_ev = (done_sync_reg[1] == done_sync_reg[2]) &&
                     (done_sync_reg[2] != done_seen_reg);
    assign req_ev = (req_sync_reg[1] == req_sync_reg[2]) &&
                    (req_sync_reg[2] != req_seen_reg);

    // Drove a zero identifier bit but another agent drove a one
    assign lose_now = (state_reg == LIC_SEND) &&
                      (cnt_reg >= CYC_ARB_FIRST) &&
                      (cnt_reg <= CYC_ARB_LAST) &&
                      bus_in[1] && !cur_val[1];

    // Sent frame finished with checksum ok and accept
    assign frame_ok = (state_reg == LIC_SEND) && (cnt_reg == CYC_IDLE) &&
                      !lost_reg && !retry_reg;

    // Register write latches the message; writes while busy are ignored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vec_hold_reg <= 8'h00;
            arb_hold_reg <= 4'h0;
            req_tgl_reg <= TGL_RESET;
        end else if (eoi_write && !busy_reg) begin // [RULE3]
            vec_hold_reg <= eoi_vector;
            arb_hold_reg <= arb_id;
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    // Busy from the write until the link reports completion
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_ev;
            if (eoi_write && !busy_reg) begin
                busy_reg <= 1'b1;
            end else if (done_ev) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Completion toggle into the system clock domain
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done_sync_reg <= SYNC_RESET;
            done_seen_reg <= TGL_RESET;
        end else begin
            done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
            if (done_sync_reg[1] == done_sync_reg[2]) begin
                done_seen_reg <= done_sync_reg[2];
            end
        end
    end

    // Request toggle into the link domain
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            req_sync_reg <= SYNC_RESET;
            req_seen_reg <= TGL_RESET;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
            if (req_sync_reg[1] == req_sync_reg[2]) begin
                req_seen_reg <= req_sync_reg[2];
            end
        end
    end

    // Pending message; stays pending through errors and lost arbitration
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= 1'b0;
            vec_reg <= 8'h00;
            arb_reg <= 4'h0;
            done_tgl_reg <= TGL_RESET;
        end else begin
            if (req_ev) begin
                pend_reg <= 1'b1; // [RULE2]
                vec_reg <= vec_hold_reg;
                arb_reg <= arb_hold_reg;
            end else if (frame_ok) begin
                pend_reg <= 1'b0;
            end
            if (frame_ok) begin
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    // Frame sequencer; foreign frames are followed, and driven only with the cycle 12 error flag
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= LIC_IDLE;
            cnt_reg <= CYC_NONE;
            code_reg <= PAIR_ZERO;
        end else begin
            unique case (state_reg)
                LIC_IDLE: begin
                    if (pend_reg) begin
                        state_reg <= LIC_SEND;
                        cnt_reg <= CYC_CODE;
                        code_reg <= CODE_EOI;
                    end else if (bus_in != PAIR_ZERO) begin // [RULE14]
                        state_reg <= LIC_LISTEN;
                        cnt_reg <= CYC_FIRST_SAMPLE;
                        code_reg <= bus_in;
                    end
                end
                LIC_SEND, LIC_LISTEN: begin
                    if (cnt_reg == CYC_IDLE) begin // [RULE2]
                        state_reg <= LIC_IDLE;
                        cnt_reg <= CYC_NONE;
                    end else begin
                        cnt_reg <= cnt_nxt; // [RULE14]
                    end
                end
            endcase
        end
    end

    // Arbitration loss stops the frame drive of this end; it can still drive the cycle 12 error flag
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lost_reg <= 1'b0;
        end else if (state_reg == LIC_IDLE) begin
            lost_reg <= 1'b0;
        end else if (lose_now) begin
            lost_reg <= 1'b1;
        end
    end

    // Checks the checksum that really appeared, not the one meant
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= PAIR_ZERO;
            err_reg <= 1'b0;
        end else if (state_reg == LIC_IDLE) begin
            acc_reg <= PAIR_ZERO;
            err_reg <= 1'b0;
        end else if (cnt_reg >= CYC_VEC_FIRST && cnt_reg <= CYC_VEC_LAST) begin
            acc_reg <= csum_step(acc_reg, bus_in,
                                 cnt_reg != CYC_VEC_LAST); // [RULE8] [RULE9]
        end else if (cnt_reg == CYC_CSUM && code_reg == CODE_EOI) begin
            err_reg <= (bus_in != acc_reg); // [RULE1] [RULE10]
        end
    end

    // Status cycles decide on a resend; anything but 00 then 10 retries
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            retry_reg <= 1'b0;
        end else if (state_reg == LIC_IDLE) begin
            retry_reg <= 1'b0;
        end else if (cnt_reg == CYC_STAT0 && bus_in != STAT_CS_OK) begin
            retry_reg <= 1'b1; // [RULE12] [RULE13]
        end else if (cnt_reg == CYC_STAT1 && bus_in != STAT_ACCEPT) begin
            retry_reg <= 1'b1; // [RULE12] [RULE13]
        end
    end

    // Drive value for the next bus cycle
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= PAIR_ZERO;
            oe_reg <= 1'b0;
        end else if (state_reg == LIC_IDLE && pend_reg) begin
            out_reg <= CODE_EOI; // [RULE4]
            oe_reg <= 1'b1;
        end else if (state_reg != LIC_IDLE && cnt_nxt == CYC_STAT0 &&
                     err_reg) begin
            out_reg <= STAT_CS_ERR; // [RULE10]
            oe_reg <= 1'b1;
        end else if (state_reg == LIC_SEND && !lost_reg && !lose_now &&
                     (cnt_nxt <= CYC_GAP || cnt_nxt == CYC_IDLE)) begin
            // Cycles 11 and 14 come out as zero from frame_val
            out_reg <= frame_val(cnt_nxt, arb_reg, vec_reg); // [RULE4]
            oe_reg <= 1'b1;
        end else begin
            out_reg <= PAIR_ZERO;
            oe_reg <= 1'b0;
        end
    end

endmodule

// ===== ibeoi_link_checker.sv
// Concurrent checks on the bus shared by the two controller ends
`timescale 1ns/1ps
module ibeoi_link_checker
    import ibeoi_pkg::*;
(
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic [1:0] lic_out,
    input wire logic lic_oe,
    input wire logic [1:0] ioc_out,
    input wire logic ioc_oe,
    input wire logic [1:0] level
);
    ibeoi_cnt_t cur; // Cycle on the bus; 0 while idle or in cycle 1
    logic [1:0] sum_lic; // Checksum of what the sender drove
    logic [1:0] sum_lvl; // Checksum of what the bus carried
    logic start; // This edge samples cycle 1 of a frame
    assign start = (cur == 4'h0) && (level != 2'h0);

    // Two-bit add; carry is folded back except on the last step
    function automatic logic [1:0] add2(input logic [1:0] a,
                                        input logic [1:0] b,
                                        input logic fold);
        logic [2:0] s;
        s = {1'b0, a} + {1'b0, b};
        add2 = s[1:0] + (fold ? {1'b0, s[2]} : 2'h0);
    endfunction

    // Frame position; every frame here is 14 cycles long
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= 4'h0;
        end else begin
            cur <= start ? 4'h2 : ((cur == 4'h0 || cur == 4'he) ? 4'h0
                                   : cur + 4'h1);
        end
    end

    // Running sums over the vector cycles 6 to 9
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            sum_lic <= 2'h0;
            sum_lvl <= 2'h0;
        end else if (cur == 4'h6) begin
            sum_lic <= lic_out;
            sum_lvl <= level;
        end else if (cur >= 4'h7 && cur <= 4'h9) begin
            sum_lic <= add2(sum_lic, lic_out, cur != 4'h9);
            sum_lvl <= add2(sum_lvl, level, cur != 4'h9);
        end
    end

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rstn);

    chk_code_pair: assert property (
        start && lic_oe |-> lic_out == 2'h3) else $error("code not 11");
    chk_gap_low: assert property (
        (cur == 4'hb || cur == 4'he) |-> level == 2'h0)
        else $error("gap or idle not 00");
    chk_arb_lsb: assert property (
        (cur >= 4'h2 && cur <= 4'h5 && lic_oe) |-> !lic_out[0])
        else $error("arb cycle low bit set");
    chk_sum_sent: assert property (
        cur == 4'ha && lic_oe |-> lic_out == sum_lic)
        else $error("wrong checksum sent");
    chk_err_flag: assert property (
        cur == 4'ha && level != sum_lvl |-> ##2 level == 2'h3)
        else $error("no error flag in status 0");
    chk_ok_quiet: assert property (
        cur == 4'ha && level == sum_lvl |-> ##2 level == 2'h0)
        else $error("status 0 not ok");
    chk_ack_code: assert property (
        cur == 4'hd && ioc_oe |-> ioc_out[1])
        else $error("bad status 1 code");
    chk_err_no_ack: assert property (
        cur == 4'hc && level == 2'h3 |=> !ioc_oe)
        else $error("answer after error");
    chk_resend_now: assert property (
        cur == 4'hd && level != 2'h2 |-> ##3 start)
        else $error("no resend");
    chk_sender_off: assert property (
        cur == 4'hd |-> !lic_oe) else $error("sender drives status 1");

    cov_cs_error: cover property (cur == 4'hc && level == 2'h3);
    cov_retry: cover property (cur == 4'hd && level == 2'h3);
    cov_accept: cover property (cur == 4'hd && level == 2'h2);
endmodule

// ===== testbench.sv
// Self-checking bench: sender and receiver ends joined on one bus
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0; // System clock, 50 ns
    logic link_clk = 1'b0; // Link clock, 48 ns
    logic rstn;
    logic eoi_write;
    logic [7:0] wr_vec;
    logic [3:0] wr_arb;
    logic busy;
    logic eoi_done;
    logic retry_req;
    logic eoi_valid;
    logic [7:0] rx_vec;
    logic [3:0] rx_arb;
    logic cs_error;
    logic [3:0] mon_cur = 4'h0; // Cycle now on the bus
    logic [1:0] lv [1:14]; // Levels of the last frame seen
    int idx;
    int mismatches = 0;
    int total_checks = 0;
    int frames = 0; // Whole frames seen
    int valids = 0; // Delivered messages
    int errs = 0; // Receiver checksum errors
    int corrupt_at = -1; // Frame number to spoil in cycle 6
    int retry_at = -1; // Frame number to answer with retry

    always #25 clock = ~clock;
    always #24 link_clk = ~link_clk;

    ibeoi_bus_if bus();
    ibeoi_lic_end i_ibeoi_lic_end (.bus(bus), .clock(clock), .rstn(rstn),
        .link_clk(link_clk), .eoi_write(eoi_write), .eoi_vector(wr_vec),
        .arb_id(wr_arb), .busy(busy), .eoi_done(eoi_done));
    ibeoi_ioc_end i_ibeoi_ioc_end (.bus(bus), .link_clk(link_clk),
        .rstn(rstn), .retry_req(retry_req), .eoi_valid(eoi_valid),
        .eoi_vector(rx_vec), .eoi_arb_id(rx_arb), .cs_error(cs_error));
    ibeoi_link_checker i_ibeoi_link_checker (.link_clk(link_clk),
        .rstn(rstn), .lic_out(bus.lic_out), .lic_oe(bus.lic_oe),
        .ioc_out(bus.ioc_out), .ioc_oe(bus.ioc_oe), .level(bus.level));

    // Bus monitor: places each sampled level at its frame cycle
    always @(posedge link_clk) begin
        idx = (mon_cur == 4'h0 && bus.level != 2'h0) ? 1 : int'(mon_cur);
        if (idx != 0) lv[idx] = bus.level;
        if (idx == 14) frames++;
        mon_cur <= (idx == 0 || idx == 14) ? 4'h0 : 4'(idx + 1);
        if (eoi_valid === 1'b1) valids++;
        if (cs_error === 1'b1) errs++;
    end

    // Third agent spoils cycle 6; retry answer is a plain level
    always @(negedge link_clk) begin
        bus.ext_oe <= (corrupt_at == frames) && (mon_cur == 4'h6);
        retry_req <= (retry_at == frames);
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Register write; waits until the sender is free, bounded
    task automatic send(input logic [7:0] v, input logic [3:0] a);
        int n;
        n = 0;
        @(negedge clock);
        while (busy !== 1'b0) begin
            if (++n > 4000) begin
                mismatches++;
                conclude();
            end
            @(negedge clock);
        end
        eoi_write = 1'b1;
        wr_vec = v;
        wr_arb = a;
        @(negedge clock);
        eoi_write = 1'b0;
        @(negedge clock);
        cmp("busy", 8'h01, {7'h0, busy});
    endtask

    // Bounded wait for the done pulse, then busy must drop
    task automatic wait_done();
        int n;
        n = 0;
        while (eoi_done !== 1'b1) begin
            if (++n > 4000) begin
                mismatches++;
                conclude();
            end
            @(negedge clock);
        end
        @(negedge clock);
        cmp("busy_end", 8'h00, {7'h0, busy});
    endtask

    // Own checksum: carry folded back on all but the last add
    function automatic logic [1:0] csum(input logic [7:0] v);
        logic [2:0] s;
        s = {1'b0, v[7:6]} + {1'b0, v[5:4]};
        s = {1'b0, s[1:0] + {1'b0, s[2]}} + {1'b0, v[3:2]};
        s = {1'b0, s[1:0] + {1'b0, s[2]}} + {1'b0, v[1:0]};
        csum = s[1:0];
    endfunction

    // Compares the last frame with the layout worked out here
    task automatic check_frame(input logic [7:0] v, input logic [3:0] a);
        logic [1:0] e [1:14];
        e = '{2'h3, {a[3], 1'b0}, {a[2], 1'b0}, {a[1], 1'b0},
              {a[0], 1'b0}, v[7:6], v[5:4], v[3:2], v[1:0], csum(v),
              2'h0, 2'h0, 2'h2, 2'h0};
        for (int k = 1; k <= 14; k++)
            cmp("level", {6'h0, e[k]}, {6'h0, lv[k]});
    endtask

    initial begin
        int f0;
        int v0;
        int e0;
        bus.ext_oe = 1'b0;
        bus.ext_out = 2'h1;
        eoi_write = 1'b0;
        wr_vec = 8'h00;
        wr_arb = 4'h0;
        retry_req = 1'b0;
        rstn = 1'b0;
        #110 rstn = 1'b1;
        // Plain message
        send(8'ha5, 4'h9);
        wait_done();
        check_frame(8'ha5, 4'h9);
        cmp("rx_vec", 8'ha5, rx_vec);
        cmp("rx_arb", 8'h09, {4'h0, rx_arb});
        $display("test plain done");
        // Receiver asks for a retry once
        f0 = frames;
        v0 = valids;
        retry_at = frames;
        send(8'h3c, 4'h6);
        wait_done();
        cmp("frames", 8'h02, 8'(frames - f0));
        cmp("valids", 8'h01, 8'(valids - v0));
        cmp("rx_vec", 8'h3c, rx_vec);
        $display("test retry done");
        // Spoiled vector cycle: error, discard, resend
        f0 = frames;
        v0 = valids;
        e0 = errs;
        corrupt_at = frames;
        send(8'h0f, 4'hf);
        wait_done();
        cmp("frames", 8'h02, 8'(frames - f0));
        cmp("valids", 8'h01, 8'(valids - v0));
        cmp("errs", 8'h01, 8'(errs - e0));
        check_frame(8'h0f, 4'hf);
        $display("test error done");
        // Write while busy is ignored; boundary values back to back
        v0 = valids;
        send(8'hff, 4'h0);
        eoi_write = 1'b1;
        wr_vec = 8'h11;
        @(negedge clock);
        eoi_write = 1'b0;
        wait_done();
        check_frame(8'hff, 4'h0);
        send(8'h00, 4'hf);
        wait_done();
        check_frame(8'h00, 4'hf);
        cmp("valids", 8'h02, 8'(valids - v0));
        $display("test refuse done");
        conclude();
    end
endmodule
